// [rtl/srs_sequencer.sv]
// Purpose: System reset sequencer: combines reset sources, times release
// Assumes: clk is the always-running reference clock; osc_tick one pulse
//          per selected-oscillator period, synchronous to clk
// Notes: Long delays are parameters so simulation can shorten them
`timescale 1ns/10ps
`default_nettype none

module srs_sequencer #(
    parameter int unsigned LOCK_CYC = srs_pkg::T_LOCK_NS / srs_pkg::CLK_PERIOD_NS,
    parameter int unsigned MONITOR_CYC = srs_pkg::T_MONITOR_NS / srs_pkg::CLK_PERIOD_NS,
    parameter int unsigned POWERUP_TIMER_STEP_CYC = srs_pkg::T_POWERUP_TIMER_STEP_NS / srs_pkg::CLK_PERIOD_NS,
    parameter int unsigned OSCD_XTAL_CYC = srs_pkg::OSCD_XTAL_DEF,
    parameter int unsigned MIN_PULSE_CYC = srs_pkg::MIN_PULSE_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_above_por,
    input wire logic supply_above_bor,
    input wire logic master_clear_pin_n,
    input wire logic reset_instr,
    input wire logic osc_tick,
    input wire logic [2:0] new_oscillator_select_cfg,
    input wire logic [1:0] primary_mode,
    input wire logic [srs_pkg::POWERUP_TIMER_SEL_W-1:0] powerup_delay_select,
    input wire logic monitor_enable,
    input wire logic [srs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [srs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [srs_pkg::DATA_W-1:0] reg_rdata,
    output logic master_reset_signal,
    output logic osc_enable,
    output logic clock_ready,
    output logic vector_fetch,
    output logic [23:0] fetch_address,
    output logic monitor_active,
    output logic [2:0] current_oscillator_select
);
    import srs_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        srs_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] mon_cnt;
        logic [1:0] por_sync;
        logic [1:0] bor_sync;
        logic [DATA_W-1:0] flags;
        logic [2:0] cur_osc;
        logic mreset;
        logic osc_en;
        logic clk_ready;
        logic fetch;
        logic [23:0] fetch_addr;
        logic mon_active;
        logic [DATA_W-1:0] rdata;
    } srs_seq_t;

    localparam srs_seq_t SEQ_RESET = '{
        st: ST_POR_EXT,
        cnt: '0,
        mon_cnt: '0,
        por_sync: 2'h0,
        bor_sync: 2'h0,
        flags: RESET_CONTROL_INIT,
        cur_osc: 3'h0,
        mreset: 1'b1,
        osc_en: 1'b0,
        clk_ready: 1'b0,
        fetch: 1'b0,
        fetch_addr: RESET_VECTOR,
        mon_active: 1'b0,
        rdata: '0
    };

    srs_seq_t s;
    srs_seq_t next_s;
    logic master_clear_pin_asserted;

    srs_clear_if clr_if ();

    assign clr_if.pin_n = master_clear_pin_n;
    assign master_clear_pin_asserted = clr_if.asserted;

    srs_clear_filter #(
        .MIN_PULSE_CYC(MIN_PULSE_CYC)
    ) u_clear_filter (
        .clk(clk),
        .rst_n(rst_n),
        .link(clr_if)
    );

    // ----------------------------------------------------------------
    // Oscillator mode decoding
    // ----------------------------------------------------------------
    function automatic logic is_primary(input logic [2:0] osc);
        return (osc == OSC_PRI) || (osc == OSC_PRI_PLL);
    endfunction : is_primary

    function automatic logic needs_oscd(input logic [2:0] osc, input logic [1:0] pri);
        return !(is_primary(osc) && pri == PRI_EXT_CLOCK);
    endfunction : needs_oscd

    function automatic logic needs_ost(input logic [2:0] osc, input logic [1:0] pri);
        return (osc == OSC_SECONDARY_OSCILLATOR) || (is_primary(osc) &&
            (pri == PRI_CRYSTAL || pri == PRI_HS_CRYSTAL));
    endfunction : needs_ost

    function automatic logic needs_lock(input logic [2:0] osc);
        return (osc == OSC_FRC_PLL) || (osc == OSC_PRI_PLL);
    endfunction : needs_lock

    function automatic logic [CNT_W-1:0] oscd_len(input logic [2:0] osc);
        if (osc == OSC_LOW_POWER_INTERNAL_RC) begin
            return OSCD_LOW_POWER_INTERNAL_RC_CYC;
        end else if (is_primary(osc) || osc == OSC_SECONDARY_OSCILLATOR) begin
            return CNT_W'(OSCD_XTAL_CYC);
        end
        return OSCD_FRC_CYC;
    endfunction : oscd_len

    // Next phase of the clock-ready chain after the current one
    function automatic srs_state_t after_phase(input srs_state_t cur,
                                               input logic [2:0] osc,
                                               input logic [1:0] pri);
        if (cur == ST_POWERUP_TIMER && needs_oscd(osc, pri)) begin
            return ST_OSCD;
        end else if ((cur == ST_POWERUP_TIMER || cur == ST_OSCD) && needs_ost(osc, pri)) begin
            return ST_OST;
        end else if (cur != ST_LOCK && needs_lock(osc)) begin
            return ST_LOCK;
        end
        return ST_RUN;
    endfunction : after_phase

    function automatic logic [CNT_W-1:0] phase_len(input srs_state_t st,
                                                   input logic [2:0] osc);
        unique case (st)
            ST_OSCD: return oscd_len(osc);
            ST_OST: return OST_CYC;
            ST_LOCK: return CNT_W'(LOCK_CYC);
            default: return '0;
        endcase
    endfunction : phase_len

    function automatic logic [CNT_W-1:0] powerup_timer_len(input logic [POWERUP_TIMER_SEL_W-1:0] sel);
        int unsigned step;
        step = (sel == '0) ? 0 : (1 << sel);
        return CNT_W'(step * POWERUP_TIMER_STEP_CYC);
    endfunction : powerup_timer_len

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    logic por_ok;
    logic bor_ok;
    logic done;
    logic cold;
    logic sw_req;

    always_comb begin
        next_s = s;
        next_s.fetch = 1'b0;
        next_s.rdata = '0;
        next_s.por_sync = {s.por_sync[0], supply_above_por};
        next_s.bor_sync = {s.bor_sync[0], supply_above_bor};
        por_ok = s.por_sync[1];
        bor_ok = s.bor_sync[1];
        done = (s.cnt <= CNT_W'(1));
        sw_req = reset_instr && (s.st == ST_RUN);
        unique case (s.st)
            ST_POR_EXT: begin
                if (!por_ok) begin
                    next_s.cnt = POR_EXT_CYC;
                end else if (done) begin
                    next_s.st = ST_BOR_EXT;
                    next_s.cnt = BOR_EXT_CYC;
                end else begin
                    next_s.cnt = s.cnt - CNT_W'(1);
                end
            end
            ST_BOR_EXT: begin
                if (!bor_ok) begin
                    next_s.cnt = BOR_EXT_CYC;
                end else if (done) begin
                    next_s.st = ST_POWERUP_TIMER;
                    next_s.cnt = powerup_timer_len(powerup_delay_select);
                end else begin
                    next_s.cnt = s.cnt - CNT_W'(1);
                end
            end
            ST_POWERUP_TIMER, ST_OSCD, ST_LOCK: begin
                if (done) begin
                    next_s.st = after_phase(s.st, s.cur_osc, primary_mode);
                    next_s.cnt = phase_len(next_s.st, s.cur_osc);
                end else begin
                    next_s.cnt = s.cnt - CNT_W'(1);
                end
            end
            ST_OST: begin
                if (osc_tick && done) begin
                    next_s.st = after_phase(s.st, s.cur_osc, primary_mode);
                    next_s.cnt = phase_len(next_s.st, s.cur_osc);
                end else if (osc_tick) begin
                    next_s.cnt = s.cnt - CNT_W'(1);
                end
            end
            ST_RUN: begin
                if (sw_req) begin
                    next_s.st = ST_SW_RST;
                end
            end
            ST_EXT_HOLD: begin
                if (!master_clear_pin_asserted) begin
                    next_s.st = ST_RUN;
                end
            end
            ST_SW_RST: begin
                next_s.st = ST_RUN;
            end
            default: begin
                next_s.st = ST_POR_EXT;
                next_s.cnt = POR_EXT_CYC;
            end
        endcase

        // Supply events override everything and restart the delays
        if (!por_ok) begin
            next_s.st = ST_POR_EXT;
            next_s.cnt = POR_EXT_CYC;
        end else if (!bor_ok) begin
            next_s.st = ST_BOR_EXT;
            next_s.cnt = BOR_EXT_CYC;
        end else if (master_clear_pin_asserted && (next_s.st == ST_RUN || next_s.st == ST_SW_RST)) begin
            next_s.st = ST_EXT_HOLD;
        end

        cold = (next_s.st == ST_POR_EXT) || (next_s.st == ST_BOR_EXT);
        if (cold) begin
            next_s.cur_osc = new_oscillator_select_cfg;
        end
        next_s.osc_en = !cold && (next_s.st != ST_POWERUP_TIMER);
        next_s.clk_ready = (next_s.st == ST_RUN) || (next_s.st == ST_EXT_HOLD)
            || (next_s.st == ST_SW_RST);
        next_s.mreset = cold || (next_s.st == ST_POWERUP_TIMER) || (next_s.st == ST_EXT_HOLD)
            || (next_s.st == ST_SW_RST) || master_clear_pin_asserted;
        if (next_s.st == ST_RUN && s.st != ST_RUN) begin
            next_s.fetch = 1'b1;
            next_s.fetch_addr = RESET_VECTOR;
        end

        // Clock-fail monitor start delay, kept across warm resets
        if (!monitor_enable || cold) begin
            next_s.mon_active = 1'b0;
            next_s.mon_cnt = CNT_W'(MONITOR_CYC);
        end else if (s.clk_ready && !s.mon_active) begin
            if (s.mon_cnt <= CNT_W'(1)) begin
                next_s.mon_active = 1'b1;
            end else begin
                next_s.mon_cnt = s.mon_cnt - CNT_W'(1);
            end
        end

        // Cause flags: software write first, hardware events win
        if (reg_wr && reg_addr == OFS_RESET_CONTROL) begin
            next_s.flags = reg_wdata & RESET_CONTROL_MASK;
        end
        if (!por_ok) begin
            next_s.flags = '0;
            next_s.flags[BIT_POR] = 1'b1;
        end else begin
            if (!bor_ok) begin
                next_s.flags[BIT_BOR] = 1'b1;
            end
            if (master_clear_pin_asserted) begin
                next_s.flags[BIT_EXTERNAL_RESET_FLAG] = 1'b1;
            end
            if (sw_req) begin
                next_s.flags[BIT_SWR] = 1'b1;
            end
        end

        if (reg_rd) begin
            if (reg_addr == OFS_RESET_CONTROL) begin
                next_s.rdata = s.flags;
            end else if (reg_addr == OFS_OSC_CONTROL) begin
                next_s.rdata = DATA_W'({s.cur_osc, CURRENT_OSCILLATOR_SELECT_LSB'(0)});
            end
        end
    end

    // Counters run on the reference clock, never the system clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= SEQ_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata = s.rdata;
    assign master_reset_signal = s.mreset;
    assign osc_enable = s.osc_en;
    assign clock_ready = s.clk_ready;
    assign vector_fetch = s.fetch;
    assign fetch_address = s.fetch_addr;
    assign monitor_active = s.mon_active;
    assign current_oscillator_select = s.cur_osc;

endmodule : srs_sequencer

`default_nettype wire

// [rtl/srs_pkg.sv]
// Purpose: Shared constants and types for the system reset sequencer
// Assumes: clk is the always-running internal reference clock at 20 MHz
// Notes: Times are kept in ns; cycle counts derive from the clock period
//
// Functional notes
// - Power-on and brown-out are cold resets; clock source comes from config word
// - Other resets are warm; clock stays as current oscillator field bits 14:12
// - After supply power-up, hold master reset for the 30 us extension
// - Brown-out holds reset while supply low, plus 100 us extension afterward
// - Power-up timer delay follows; then master reset releases, oscillator starts
// - Power-up delay from 3-bit config field, eight settings 0 to 128 ms
// - Extension plus power-up delay restart on every supply recovery
// - Clock-ready delay chain depends on oscillator mode
// - Crystal and secondary modes count 1024 oscillator periods
// - PLL modes wait 1.5 ms lock time
// - Start-up delay 1.1 us for fast RC, 70 us for low-power RC
// - When clock ready, processor fetches from address zero
// - Clock-fail monitor starts 900 us after clock ready, if enabled
// - Power-on sets cause flag bit 0
// - Brown-out sets cause flag bit 1
// - Master clear pin low past minimum width resets and sets its flag
// - Reset instruction pulses master reset one cycle, keeps clock, refetches
// - Software reset sets cause flag bit 6
// - Master reset is the OR of all active reset sources
// - Power-on clears other flags; software may set or clear any flag
// - External reset cause flag sits at bit 7

package srs_pkg;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] OFS_RESET_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_OSC_CONTROL = 4'h1;
    localparam int BIT_POR = 0;
    localparam int BIT_BOR = 1;
    localparam int BIT_SWR = 6;
    localparam int BIT_EXTERNAL_RESET_FLAG = 7;
    localparam int CURRENT_OSCILLATOR_SELECT_LSB = 12;
    localparam logic [DATA_W-1:0] RESET_CONTROL_INIT = 16'h0003;
    localparam logic [DATA_W-1:0] RESET_CONTROL_MASK = 16'h00c3;
    localparam logic [23:0] RESET_VECTOR = 24'h000000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CNT_W = 22;
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_POR_EXT_NS = 30000;
    localparam int T_BOR_EXT_NS = 100000;
    localparam int T_OSCD_FRC_NS = 1100;
    localparam int T_OSCD_LOW_POWER_INTERNAL_RC_NS = 70000;
    localparam int T_LOCK_NS = 1500000;
    localparam int T_MONITOR_NS = 900000;
    localparam int T_POWERUP_TIMER_STEP_NS = 1000000;
    localparam int OST_PERIODS = 1024;
    localparam int POWERUP_TIMER_SEL_W = 3;
    localparam int MIN_PULSE_DEF = 4;
    localparam int OSCD_XTAL_DEF = 1;
    localparam logic [CNT_W-1:0] POR_EXT_CYC = CNT_W'(T_POR_EXT_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] BOR_EXT_CYC = CNT_W'(T_BOR_EXT_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] OSCD_FRC_CYC = CNT_W'(T_OSCD_FRC_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] OSCD_LOW_POWER_INTERNAL_RC_CYC = CNT_W'(T_OSCD_LOW_POWER_INTERNAL_RC_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] OST_CYC = CNT_W'(OST_PERIODS);

    // ----------------------------------------------------------------
    // Oscillator selections and sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OSC_FRC = 3'b000,
        OSC_FRC_PLL = 3'b001,
        OSC_PRI = 3'b010,
        OSC_PRI_PLL = 3'b011,
        OSC_SECONDARY_OSCILLATOR = 3'b100,
        OSC_LOW_POWER_INTERNAL_RC = 3'b101,
        OSC_FRC_DIV16 = 3'b110,
        OSC_FRC_DIVN = 3'b111
    } srs_osc_t;

    typedef enum logic [1:0] {
        PRI_EXT_CLOCK = 2'b00,
        PRI_CRYSTAL = 2'b01,
        PRI_HS_CRYSTAL = 2'b10
    } srs_pri_t;

    typedef enum logic [3:0] {
        ST_POR_EXT = 4'b0000,
        ST_BOR_EXT = 4'b0001,
        ST_POWERUP_TIMER = 4'b0010,
        ST_OSCD = 4'b0011,
        ST_OST = 4'b0100,
        ST_LOCK = 4'b0101,
        ST_RUN = 4'b0110,
        ST_EXT_HOLD = 4'b0111,
        ST_SW_RST = 4'b1000
    } srs_state_t;

endpackage : srs_pkg

// [rtl/srs_clear_if.sv]
// Purpose: Carrier between the sequencer and its master clear filter
// Assumes: pin level is raw and asynchronous
// Notes: asserted is a registered level
`timescale 1ns/10ps
`default_nettype none

interface srs_clear_if;
    logic pin_n;
    logic asserted;
    modport filt (input pin_n, output asserted);
    modport seq (output pin_n, input asserted);
endinterface : srs_clear_if

`default_nettype wire

// [rtl/srs_clear_filter.sv]
// Purpose: Synchronise and glitch-filter the master clear pin
// Assumes: pin is active low and asynchronous
// Notes: asserted rises after MIN_PULSE_CYC low samples, falls on first high
`timescale 1ns/10ps
`default_nettype none

module srs_clear_filter #(
    parameter int MIN_PULSE_CYC = srs_pkg::MIN_PULSE_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    srs_clear_if.filt link
);
    import srs_pkg::*;

    typedef struct packed {
        logic [1:0] sync;
        logic [15:0] cnt;
        logic asserted;
    } srs_filt_t;

    srs_filt_t s;
    srs_filt_t next_s;

    always_comb begin
        next_s = s;
        next_s.sync = {s.sync[0], link.pin_n};
        if (s.sync[1]) begin
            next_s.cnt = '0;
            next_s.asserted = 1'b0;
        end else if (s.cnt >= 16'(MIN_PULSE_CYC - 1)) begin
            next_s.asserted = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '{sync: 2'h3, cnt: 16'h0000, asserted: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign link.asserted = s.asserted;

endmodule : srs_clear_filter

`default_nettype wire

// [rtl/srs_dummy_unused.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [bench/srs_sequencer_props.sv]
// Purpose: Port-level checks of the reset sequencer
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every sequencer instance
`timescale 1ns/10ps
`default_nettype none

module srs_sequencer_props #(
    parameter int unsigned MONITOR_CYC = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_above_bor,
    input wire logic master_clear_pin_n,
    input wire logic reset_instr,
    input wire logic [2:0] new_oscillator_select_cfg,
    input wire logic monitor_enable,
    input wire logic master_reset_signal,
    input wire logic osc_enable,
    input wire logic clock_ready,
    input wire logic vector_fetch,
    input wire logic [23:0] fetch_address,
    input wire logic monitor_active,
    input wire logic [2:0] current_oscillator_select
);
    import srs_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Release and hold steps
    // ------------------------------------------------------------
    sequence swr_release_s;
        master_reset_signal ##1 (!master_reset_signal && vector_fetch);
    endsequence

    swr_release_a:
        assert property (reset_instr && clock_ready && !master_reset_signal |=> swr_release_s)
        else $error("reset instruction gave no one-cycle master reset");
    warm_clock_a:
        assert property (reset_instr && clock_ready && !master_reset_signal |=>
            ##1 current_oscillator_select == $past(current_oscillator_select, 2))
        else $error("clock source changed on warm reset");
    cold_clock_a:
        assert property ($rose(osc_enable) |-> current_oscillator_select == new_oscillator_select_cfg)
        else $error("cold reset did not load clock source from config");
    fetch_zero_a:
        assert property (vector_fetch |-> fetch_address == 24'h000000)
        else $error("vector fetch not at address zero");
    ready_fetch_a:
        assert property ($rose(clock_ready) |-> vector_fetch)
        else $error("clock ready without vector fetch");
    fetch_pulse_a:
        assert property (vector_fetch |=> !vector_fetch)
        else $error("vector fetch longer than one cycle");
    osc_release_a:
        assert property (clock_ready |-> osc_enable)
        else $error("clock ready while oscillator held off");
    monitor_delay_a:
        assert property ($rose(monitor_active) |->
            monitor_enable && clock_ready && $past(clock_ready, MONITOR_CYC))
        else $error("clock monitor started early");
    brownout_hold_a:
        assert property (!supply_above_bor [*4] |-> master_reset_signal)
        else $error("low supply without master reset");
    pin_hold_a:
        assert property (!master_clear_pin_n [*8] |-> master_reset_signal)
        else $error("long clear pulse without master reset");
endmodule : srs_sequencer_props

bind srs_sequencer srs_sequencer_props #(.MONITOR_CYC(MONITOR_CYC)) srs_sequencer_props_inst (
    .clk, .rst_n, .supply_above_bor, .master_clear_pin_n, .reset_instr,
    .new_oscillator_select_cfg, .monitor_enable, .master_reset_signal, .osc_enable,
    .clock_ready, .vector_fetch, .fetch_address, .monitor_active, .current_oscillator_select
);

`default_nettype wire

// [bench/srs_supervisor.sv]
// Purpose: External supervisor driving the master clear pin
// Assumes: pin has no pull-up, so the model always drives it
// Notes: pulse length in clock cycles, changes just after an edge
`timescale 1ns/10ps
`default_nettype none

module srs_supervisor (
    input wire logic clk,
    output var logic master_clear_pin_n
);
    initial master_clear_pin_n = 1'b1;

    task automatic pulse(input int cycles);
        @(posedge clk);
        master_clear_pin_n <= 1'b0;
        repeat (cycles) @(posedge clk);
        master_clear_pin_n <= 1'b1;
    endtask : pulse
endmodule : srs_supervisor

`default_nettype wire

// [bench/test_system_reset_sequencer.sv]
// Purpose: Self-checking bench for the reset sequencer
// Assumes: shortened lock, monitor and power-up step counts
// Notes: osc_tick pulses every other cycle
`timescale 1ns/10ps
`default_nettype none

module test_system_reset_sequencer;
    import srs_pkg::*;
    localparam int MON = 20;
    localparam int STEP = 5;
    typedef struct {logic [2:0] pw; logic [2:0] osc; logic [1:0] pri; int chain;} srs_row_t;
    srs_row_t rows [10] = '{'{3'h0, 3'h0, 2'h0, 22}, '{3'h1, 3'h1, 2'h0, 42},
        '{3'h2, 3'h2, 2'h0, 0}, '{3'h3, 3'h2, 2'h1, 2049}, '{3'h4, 3'h3, 2'h0, 20},
        '{3'h5, 3'h4, 2'h0, 2049}, '{3'h6, 3'h5, 2'h0, 1400}, '{3'h7, 3'h6, 2'h0, 22},
        '{3'h0, 3'h7, 2'h0, 22}, '{3'h1, 3'h3, 2'h2, 2069}};
    logic clk = 1'b0, rst_n = 1'b0, supply_above_por = 1'b1, supply_above_bor = 1'b1;
    logic reset_instr = 1'b0, osc_tick = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic monitor_enable = 1'b1, master_clear_pin_n;
    logic [2:0] new_oscillator_select_cfg = 3'h0, powerup_delay_select = 3'h0;
    logic [1:0] primary_mode = 2'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
    logic master_reset_signal, osc_enable, clock_ready, vector_fetch, monitor_active;
    logic [23:0] fetch_address;
    logic [2:0] current_oscillator_select;
    int fail_count = 0, tests_run = 0, cyc = 0, n, lo;

    srs_sequencer #(.LOCK_CYC(20), .MONITOR_CYC(MON), .POWERUP_TIMER_STEP_CYC(STEP)) srs_sequencer_inst (
        .clk, .rst_n, .supply_above_por, .supply_above_bor, .master_clear_pin_n, .reset_instr,
        .osc_tick, .new_oscillator_select_cfg, .primary_mode, .powerup_delay_select,
        .monitor_enable, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .master_reset_signal, .osc_enable, .clock_ready, .vector_fetch, .fetch_address,
        .monitor_active, .current_oscillator_select);
    srs_supervisor srs_supervisor_inst (.clk, .master_clear_pin_n);

    always #25 clk = ~clk;
    always @(posedge clk) begin
        osc_tick <= ~osc_tick;
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic wait_until(input bit rdy, output int k);
        k = 0;
        while ((rdy ? clock_ready : !master_reset_signal) !== 1'b1 && k < 20000) begin
            @(posedge clk);
            #1 k++;
        end
    endtask : wait_until

    task automatic conclude();
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            new_oscillator_select_cfg <= rows[i].osc;
            primary_mode <= rows[i].pri;
            powerup_delay_select <= rows[i].pw;
            supply_above_por <= 1'b0;
            supply_above_bor <= 1'b0;
            repeat (5) @(posedge clk);
            supply_above_por <= 1'b1;
            supply_above_bor <= 1'b1;
            lo = 2602 + ((rows[i].pw == 3'h0) ? 1 : (STEP << rows[i].pw));
            wait_until(1'b0, n);
            check(32'(n >= lo - 1 && n <= lo + 4), 32'h1);
            check(osc_enable, 1'b1);
            wait_until(1'b1, n);
            check(32'(n >= rows[i].chain - 1 && n <= rows[i].chain + 6), 32'h1);
            check(current_oscillator_select, rows[i].osc);
            repeat (MON + 2) @(posedge clk);
            check(monitor_active, 1'b1);
            rd(4'h0, d);
            check(d, 16'h0001);
            wr(4'h0, 16'h0000);
        end
        rd(4'h1, d);
        check(d, 16'h3000);
        wr(4'h1, 16'h0000);
        rd(4'h1, d);
        check(d, 16'h3000);
        wr(4'h0, 16'hffff);
        rd(4'h0, d);
        check(d, 16'h00c3);
        rd(4'hf, d);
        check(d, 16'h0000);
        @(posedge clk);
        monitor_enable <= 1'b0;
        repeat (2) @(posedge clk);
        check(monitor_active, 1'b0);
        wr(4'h0, 16'h0000);
        srs_supervisor_inst.pulse(2);
        repeat (10) @(posedge clk);
        check(master_reset_signal, 1'b0);
        srs_supervisor_inst.pulse(12);
        #1 check(master_reset_signal, 1'b1);
        repeat (10) @(posedge clk);
        check(master_reset_signal, 1'b0);
        check(current_oscillator_select, 3'h3);
        rd(4'h0, d);
        check(d, 16'h0080);
        wr(4'h0, 16'h0000);
        @(posedge clk);
        reset_instr <= 1'b1;
        @(posedge clk);
        reset_instr <= 1'b0;
        #1 check(master_reset_signal, 1'b1);
        @(posedge clk);
        #1 check(vector_fetch & ~master_reset_signal, 1'b1);
        rd(4'h0, d);
        check(d, 16'h0040);
        check(current_oscillator_select, 3'h3);
        wr(4'h0, 16'h0000);
        supply_above_bor <= 1'b0;
        repeat (10) @(posedge clk);
        supply_above_bor <= 1'b1;
        repeat (300) @(posedge clk);
        check(master_reset_signal, 1'b1);
        supply_above_bor <= 1'b0;
        repeat (10) @(posedge clk);
        supply_above_bor <= 1'b1;
        wait_until(1'b0, n);
        check(32'(n >= 2011 && n <= 2016), 32'h1);
        rd(4'h0, d);
        check(d, 16'h0002);
        conclude();
    end
endmodule : test_system_reset_sequencer

`default_nettype wire
